// >>> mcuie_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE_01) Call pushes next address, loads target; call and jump take two cycles
// (RULE_02) Conditional skip takes one cycle, or two when it skips
// (RULE_03) Any write to program counter low byte takes two cycles
// (RULE_04) Pre-clear pair clears watchdog and flags only when back to back
// (RULE_05) Watchdog clear clears counter, expired flag and power-down flag
// (RULE_06) Add with carry sums accumulator, memory byte and carry
// (RULE_07) Memory-destination arithmetic writes the byte instead of the accumulator
// (RULE_08) Add and subtract update signed range, zero, nibble carry, carry
// (RULE_09) Subtract memory or immediate from accumulator, optionally with carry
// (RULE_10) AND, OR, XOR with memory or immediate update only zero
// (RULE_11) Complement to memory or accumulator, zero flag only
// (RULE_12) Increment and decrement by one, zero flag only
// (RULE_13) Plain rotates keep flags; rotates through carry touch only carry
// (RULE_14) Moves take one cycle, two when the move writes the program counter low byte, and alter no flag
// (RULE_15) Byte clear writes zeros, byte set writes ones, flags kept
// (RULE_16) Bit clear and set change only bit zero to seven
// (RULE_17) Skip on zero byte, bit state, or zero after step
// (RULE_18) Table reads fetch page word, high to table-high, low to memory
// (RULE_19) Nibble swap in place or to accumulator, no flags
// (RULE_20) Decimal adjust writes corrected accumulator to memory, carry only
// (RULE_21) Power-down instruction takes one cycle, touches expired and power-down
// (RULE_22) Returns restore program counter from stack in two cycles
// (RULE_23) One instruction cycle is four clocks
// (RULE_24) Power-down stops execution and clock, clears watchdog, sets power-down flag
// (RULE_25) Interrupt return also sets the global interrupt enable
// (RULE_26) Decimal adjust adds six per nibble above nine or carried
// (RULE_27) Memory destinations read old value before writing new one
module mcuie_core
  import mcuie_pkg::*;
#(
  parameter int STACK_DEPTH = 4,
  parameter int DMEM_DEPTH = 64
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  output logic [PC_W-1:0] o_pmem_addr,
  input wire logic [PWORD_W-1:0] i_pmem_data,
  input wire logic [7:0] i_table_ptr,
  input wire logic [1:0] i_table_page,
  input wire logic i_wdt_timeout,
  input wire logic i_wake,
  input wire logic i_irq_ack,
  output logic [DATA_W-1:0] o_acc,
  output logic o_carry_flag,
  output logic o_nibble_carry_flag,
  output logic o_zero_flag,
  output logic o_signed_range_flag,
  output logic o_watchdog_expired_flag,
  output logic o_power_down_flag,
  output logic [DATA_W-1:0] o_table_high_byte,
  output logic o_global_irq_enable,
  output logic o_wdt_clear,
  output logic o_sys_clk_stop
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
    $error("STACK_DEPTH must be a power of two, at least 2");
  end
  if (DMEM_DEPTH != (1 << DADDR_W)) begin : g_bad_dmem
    $error("DMEM_DEPTH must match the data address field");
  end

  // Returns {signed range, nibble carry, carry, sum}; subtract passes ~b
  function automatic logic [10:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [7:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    s = {hi[3:0], lo[3:0]};
    arith = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], hi[4], s};
  endfunction

  logic [1:0] phase;
  mcuie_run_e run;
  mcuie_prewipe_e pw;
  logic flush;
  logic tbl_pending;
  logic [PWORD_W-1:0] ir;
  logic [PWORD_W-1:0] tbl_word;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [DATA_W-1:0] dmem_rdata;
  mcuie_op_e op;
  logic [DADDR_W-1:0] maddr;
  logic [7:0] imm;
  logic [2:0] bsel;
  logic [7:0] mval;
  logic exec;
  logic dummy_end;
  logic [10:0] alu;
  logic [8:0] bcd;
  logic [7:0] res;
  logic wr_acc;
  logic wr_mem;
  logic upd_z;
  logic upd_arith;
  logic upd_c;
  logic new_c;
  logic cond_op;
  logic skip;
  logic branch;
  logic push;
  logic pop;
  logic table_op;
  logic pc_low_wr;
  logic two_cycle;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] tbl_addr;
  logic dmem_we;

  assign op = mcuie_op_e'(ir[OPC_LSB +: 6]);
  assign maddr = ir[DADDR_W-1:0];
  assign imm = ir[7:0];
  assign bsel = ir[BIT_LSB +: 3];
  // Program counter low byte reads back the live counter, not memory
  assign mval = (maddr == PC_LOW_ADDR) ? pc[7:0] : dmem_rdata;
  assign exec = (phase == PH_EXEC) && (run == ST_RUN) && !flush;
  assign dummy_end = (phase == PH_EXEC) && (run == ST_RUN) && flush;

  always_comb begin
    alu = arith(o_acc, mval, 1'b0);
    bcd = {1'b0, o_acc};
    res = mval;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    upd_arith = 1'b0;
    upd_c = 1'b0;
    new_c = o_carry_flag;
    cond_op = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    table_op = 1'b0;
    unique case (op)
      OP_ADD, OP_ADDM, OP_ADDI, OP_ADC, OP_ADCM, OP_SUB, OP_SUBM, OP_SUBI, OP_SBC,
      OP_SBCM: begin
        unique case (op)
          OP_ADDI: alu = arith(o_acc, imm, 1'b0);
          OP_ADC, OP_ADCM: alu = arith(o_acc, mval, o_carry_flag); // RULE_06
          OP_SUB, OP_SUBM: alu = arith(o_acc, ~mval, 1'b1); // RULE_09
          OP_SUBI: alu = arith(o_acc, ~imm, 1'b1); // RULE_09
          OP_SBC, OP_SBCM: alu = arith(o_acc, ~mval, o_carry_flag); // RULE_09
          default: alu = arith(o_acc, mval, 1'b0);
        endcase
        res = alu[7:0];
        upd_z = 1'b1;
        upd_arith = 1'b1; // RULE_08
        wr_mem = (op == OP_ADDM) || (op == OP_ADCM) || (op == OP_SUBM) || (op == OP_SBCM); // RULE_07
        wr_acc = !wr_mem;
      end
      OP_BCD_FIXUP: begin
        if (o_acc[3:0] > BCD_NIBBLE_MAX || o_nibble_carry_flag) begin
          bcd = bcd + BCD_FIX_LO; // RULE_26
        end
        if (o_acc[7:4] > BCD_NIBBLE_MAX || o_carry_flag) begin
          bcd = bcd + BCD_FIX_HI; // RULE_26
        end
        res = bcd[7:0];
        wr_mem = 1'b1; // RULE_20
        upd_c = 1'b1;
        new_c = bcd[8] | o_carry_flag;
      end
      OP_AND, OP_ANDM: res = o_acc & mval; // RULE_10
      OP_OR, OP_ORM: res = o_acc | mval;
      OP_XOR, OP_XORM: res = o_acc ^ mval;
      OP_ANDI: res = o_acc & imm;
      OP_ORI: res = o_acc | imm;
      OP_XORI: res = o_acc ^ imm;
      OP_CPL, OP_CPLA: res = ~mval; // RULE_11
      OP_INC, OP_INCA, OP_SIZ, OP_SIZA: res = mval + 8'h01; // RULE_12
      OP_DEC, OP_DECA, OP_SDZ, OP_SDZA: res = mval - 8'h01;
      OP_RR, OP_RRA: res = {mval[0], mval[7:1]}; // RULE_13
      OP_RL, OP_RLA: res = {mval[6:0], mval[7]};
      OP_RRC, OP_RRCA: begin
        res = {o_carry_flag, mval[7:1]};
        upd_c = 1'b1;
        new_c = mval[0];
      end
      OP_RLC, OP_RLCA: begin
        res = {mval[6:0], o_carry_flag};
        upd_c = 1'b1;
        new_c = mval[7];
      end
      OP_MOVMA: res = o_acc; // RULE_14
      OP_MOVI, OP_RETA: res = imm;
      OP_BCLR: res = mval & ~(8'h01 << bsel); // RULE_16
      OP_BSET: res = mval | (8'h01 << bsel);
      OP_CLRM: res = 8'h00; // RULE_15
      OP_SETM: res = 8'hFF;
      OP_SWAP, OP_SWAPA: res = {mval[3:0], mval[7:4]}; // RULE_19
      OP_JMP: branch = 1'b1; // RULE_01
      OP_CALL: begin
        branch = 1'b1;
        push = 1'b1; // RULE_01
      end
      OP_TBL_PAGE, OP_TBL_LOCAL, OP_TBL_FINAL: table_op = 1'b1; // RULE_18
      default: res = mval;
    endcase
    unique case (op)
      OP_ANDM, OP_ORM, OP_XORM, OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL, OP_RLC,
      OP_MOVMA, OP_BCLR, OP_BSET, OP_CLRM, OP_SETM, OP_SWAP, OP_SIZ, OP_SDZ:
        wr_mem = 1'b1; // RULE_07
      OP_AND, OP_OR, OP_XOR, OP_ANDI, OP_ORI, OP_XORI, OP_CPLA, OP_INCA, OP_DECA,
      OP_RRA, OP_RRCA, OP_RLA, OP_RLCA, OP_MOVAM, OP_MOVI, OP_SWAPA, OP_SZA, OP_SIZA,
      OP_SDZA, OP_RETA:
        wr_acc = 1'b1;
      default: ;
    endcase
    unique case (op)
      OP_AND, OP_OR, OP_XOR, OP_ANDM, OP_ORM, OP_XORM, OP_ANDI, OP_ORI, OP_XORI,
      OP_CPL, OP_CPLA, OP_INC, OP_INCA, OP_DEC, OP_DECA:
        upd_z = 1'b1; // RULE_10
      OP_SZ, OP_SZA: begin
        cond_op = 1'b1;
        skip = (mval == 8'h00); // RULE_17
      end
      OP_SZB, OP_SNZB: begin
        cond_op = 1'b1;
        skip = mval[bsel] ^ (op == OP_SZB); // RULE_17
      end
      OP_SIZ, OP_SDZ, OP_SIZA, OP_SDZA: begin
        cond_op = 1'b1;
        skip = (res == 8'h00); // RULE_17
      end
      OP_RET, OP_RETA, OP_IRQ_RETURN: pop = 1'b1; // RULE_22
      default: ;
    endcase
    pc_low_wr = wr_mem && (maddr == PC_LOW_ADDR);
    two_cycle = branch || pop || skip || pc_low_wr || table_op; // RULE_03
    next_pc = pc + 10'h001;
    if (branch) begin
      next_pc = ir[PC_W-1:0];
    end else if (pop) begin
      next_pc = stack[sp - SP_W'(1)]; // RULE_22
    end else if (skip) begin
      next_pc = pc + 10'h002; // RULE_02
    end else if (pc_low_wr) begin
      next_pc = {pc[PC_W-1:8], res}; // RULE_03
    end
    unique case (op)
      OP_TBL_PAGE: tbl_addr = {i_table_page, i_table_ptr};
      OP_TBL_LOCAL: tbl_addr = {pc[PC_W-1:8], i_table_ptr};
      default: tbl_addr = {LAST_PAGE, i_table_ptr};
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase <= PH_FETCH;
    end else begin
      phase <= phase + 2'h1; // RULE_23
    end
  end

  // In a dummy cycle the fetched word is dropped, or kept as table data
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ir <= IR_RESET;
      tbl_word <= IR_RESET;
    end else if (phase == PH_DECODE) begin
      if (!flush) begin
        ir <= i_pmem_data;
      end else if (tbl_pending) begin
        tbl_word <= i_pmem_data; // RULE_18
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pc <= PC_RESET;
      o_pmem_addr <= PC_RESET;
      flush <= 1'b0;
      tbl_pending <= 1'b0;
    end else if (exec) begin
      pc <= next_pc;
      o_pmem_addr <= table_op ? tbl_addr : next_pc; // RULE_18
      flush <= two_cycle; // RULE_01
      tbl_pending <= table_op;
    end else if (dummy_end) begin
      o_pmem_addr <= pc;
      flush <= 1'b0;
      tbl_pending <= 1'b0;
    end
  end

  // Overflowing the stack wraps and overwrites the oldest entry
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sp <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= PC_RESET;
      end
    end else if (exec && push) begin
      stack[sp] <= pc + 10'h001; // RULE_01
      sp <= sp + SP_W'(1);
    end else if (exec && pop) begin
      sp <= sp - SP_W'(1); // RULE_22
    end
  end

  assign dmem_we = (exec && wr_mem && !pc_low_wr) || (dummy_end && tbl_pending); // RULE_27

  mcuie_dmem #(
    .WIDTH(DATA_W),
    .DEPTH(DMEM_DEPTH)
  ) u_dmem (
    .i_mclk(i_mclk),
    .i_we(dmem_we),
    .i_waddr(maddr),
    .i_wdata(tbl_pending ? tbl_word[7:0] : res),
    .i_raddr(maddr),
    .o_rdata(dmem_rdata)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_acc <= ACC_RESET;
      o_table_high_byte <= ACC_RESET;
    end else if (exec && wr_acc) begin
      o_acc <= res; // RULE_14
    end else if (dummy_end && tbl_pending) begin
      o_table_high_byte <= tbl_word[15:8]; // RULE_18
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_carry_flag <= 1'b0;
      o_nibble_carry_flag <= 1'b0;
      o_zero_flag <= 1'b0;
      o_signed_range_flag <= 1'b0;
    end else if (exec) begin
      if (upd_z) begin
        o_zero_flag <= (res == 8'h00);
      end
      if (upd_arith) begin
        {o_signed_range_flag, o_nibble_carry_flag, o_carry_flag} <= alu[10:8]; // RULE_08
      end else if (upd_c) begin
        o_carry_flag <= new_c; // RULE_13
      end
    end
  end

  // A time-out in the same cycle as a clear still raises the flag
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pw <= PW_NONE;
      o_wdt_clear <= 1'b0;
      o_watchdog_expired_flag <= 1'b0;
      o_power_down_flag <= 1'b0;
    end else begin
      o_wdt_clear <= 1'b0;
      if (exec) begin
        pw <= PW_NONE;
        if (op == OP_WDT_CLEAR || op == OP_HALT || (op == OP_PREWIPE1 && pw == PW_SECOND)
            || (op == OP_PREWIPE2 && pw == PW_FIRST)) begin
          o_wdt_clear <= 1'b1; // RULE_05
          o_watchdog_expired_flag <= 1'b0; // RULE_04
          o_power_down_flag <= (op == OP_HALT); // RULE_21
        end else if (op == OP_PREWIPE1) begin
          pw <= PW_FIRST; // RULE_04
        end else if (op == OP_PREWIPE2) begin
          pw <= PW_SECOND;
        end
      end
      if (i_wdt_timeout) begin
        o_watchdog_expired_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run <= ST_RUN;
      o_sys_clk_stop <= 1'b0;
    end else begin
      unique case (run)
        ST_RUN: begin
          if (exec && op == OP_HALT) begin
            run <= ST_HALT; // RULE_24
            o_sys_clk_stop <= 1'b1;
          end
        end
        ST_HALT: begin
          if (i_wake) begin
            run <= ST_RUN;
            o_sys_clk_stop <= 1'b0;
          end
        end
        default: begin
          run <= ST_RUN;
          o_sys_clk_stop <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_global_irq_enable <= 1'b0;
    end else if (exec && op == OP_IRQ_RETURN) begin
      o_global_irq_enable <= 1'b1; // RULE_25
    end else if (i_irq_ack) begin
      o_global_irq_enable <= 1'b0;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_dummy_then_run;
    ##4 !exec ##4 exec;
  endsequence
  sequence s_next_run;
    ##4 exec;
  endsequence

  a_phase_cycle: assert property (phase == PH_FETCH |=> phase == PH_DECODE ##1 // RULE_23
    phase == PH_READ ##1 phase == PH_EXEC ##1 phase == PH_FETCH)
    else $error("instruction cycle is not four clocks");
  a_branch_timing: assert property (exec && (op == OP_JMP || op == OP_CALL) // RULE_01
    |-> s_dummy_then_run ##0 (pc == $past(ir[PC_W-1:0], 8)))
    else $error("jump or call not two cycles to target");
  a_call_push: assert property (exec && op == OP_CALL |=> sp == $past(sp) + SP_W'(1)) // RULE_01
    else $error("call did not push");
  a_skip_taken: assert property (exec && skip |-> s_dummy_then_run) // RULE_02
    else $error("taken skip not two cycles");
  a_skip_fall: assert property (exec && cond_op && !skip |-> s_next_run) // RULE_02
    else $error("untaken skip not one cycle");
  a_pc_low_jump: assert property (exec && pc_low_wr |-> s_dummy_then_run) // RULE_03
    else $error("program counter write not two cycles");
  a_return_timing: assert property (exec && pop |-> s_dummy_then_run) // RULE_22
    else $error("return not two cycles");
  a_prewipe_alone: assert property (exec && op == OP_PREWIPE1 && pw != PW_SECOND // RULE_04
    |=> !o_wdt_clear && $stable(o_power_down_flag))
    else $error("lone pre-clear had effect");
  a_wdt_clear: assert property (exec && op == OP_WDT_CLEAR && !i_wdt_timeout // RULE_05
    |=> o_wdt_clear && !o_watchdog_expired_flag && !o_power_down_flag)
    else $error("watchdog clear incomplete");
  a_halt_entry: assert property (exec && op == OP_HALT && !i_wdt_timeout // RULE_24
    |=> o_power_down_flag && !o_watchdog_expired_flag && o_sys_clk_stop && run == ST_HALT)
    else $error("power-down entry wrong");
  a_halt_still: assert property (run == ST_HALT |-> !exec && !dmem_we && o_sys_clk_stop) // RULE_24
    else $error("execution while halted");
  a_move_flags: assert property (exec && op == OP_MOVAM |=> o_acc == $past(mval) // RULE_14
    && $stable({o_zero_flag, o_carry_flag, o_nibble_carry_flag, o_signed_range_flag}))
    else $error("move changed flags or lost data");
  a_rotate_keep: assert property (exec && (op == OP_RR || op == OP_RRA || op == OP_RLA) // RULE_13
    |=> $stable({o_zero_flag, o_carry_flag, o_nibble_carry_flag, o_signed_range_flag}))
    else $error("plain rotate changed flags");
  a_logic_flags: assert property (exec && (op == OP_AND || op == OP_XORI) // RULE_10
    |=> $stable(o_carry_flag) && o_zero_flag == (o_acc == 8'h00))
    else $error("logic flag update wrong");
  a_irq_return: assert property (exec && op == OP_IRQ_RETURN |=> o_global_irq_enable) // RULE_25
    else $error("interrupt return left enable clear");
  a_mem_write: assert property (dmem_we |-> phase == PH_EXEC) // RULE_27
    else $error("memory write outside execute phase");
endmodule
`default_nettype wire

// >>> mcuie_pkg.sv
package mcuie_pkg;
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 6;
  localparam int PWORD_W = 16;
  localparam int OPC_LSB = 10;
  localparam int BIT_LSB = 6;
  localparam int CLKS_PER_ICYCLE = 4;
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_DECODE = 2'h1;
  localparam logic [1:0] PH_READ = 2'h2;
  localparam logic [1:0] PH_EXEC = 2'h3;
  localparam logic [DADDR_W-1:0] PC_LOW_ADDR = 6'h06;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PWORD_W-1:0] IR_RESET = 16'h0000;
  localparam logic [1:0] LAST_PAGE = 2'h3;
  localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDM, OP_ADDI, OP_ADC, OP_ADCM, OP_SUB, OP_SUBM, OP_SUBI,
    OP_SBC, OP_SBCM, OP_BCD_FIXUP, OP_AND, OP_OR, OP_XOR, OP_ANDM, OP_ORM, OP_XORM,
    OP_ANDI, OP_ORI, OP_XORI, OP_CPL, OP_CPLA, OP_INC, OP_INCA, OP_DEC, OP_DECA,
    OP_RR, OP_RRA, OP_RRC, OP_RRCA, OP_RL, OP_RLA, OP_RLC, OP_RLCA, OP_MOVAM,
    OP_MOVMA, OP_MOVI, OP_BCLR, OP_BSET, OP_JMP, OP_SZ, OP_SZA, OP_SZB, OP_SNZB,
    OP_SIZ, OP_SDZ, OP_SIZA, OP_SDZA, OP_CALL, OP_RET, OP_RETA, OP_IRQ_RETURN,
    OP_TBL_PAGE, OP_TBL_LOCAL, OP_TBL_FINAL, OP_CLRM, OP_SETM, OP_WDT_CLEAR,
    OP_PREWIPE1, OP_PREWIPE2, OP_SWAP, OP_SWAPA, OP_HALT
  } mcuie_op_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } mcuie_run_e;

  typedef enum logic [2:0] {
    PW_NONE = 3'b001,
    PW_FIRST = 3'b010,
    PW_SECOND = 3'b100
  } mcuie_prewipe_e;
endpackage

// >>> mcuie_dmem.sv
`timescale 1ns/1ps
`default_nettype none
module mcuie_dmem
  import mcuie_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = 64
) (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("DEPTH must be at least 2 and WIDTH at least 1");
  end

  // No reset: contents must survive power-down and soft events
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// >>> mcuie_pmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcuie_pmem_model
  import mcuie_pkg::*;
(
  input wire logic [PC_W-1:0] i_addr,
  output logic [PWORD_W-1:0] o_data
);
  // Loaded by the bench before reset is released, so no fetch sees stale words
  logic [PWORD_W-1:0] mem [0:1023];

  // Asynchronous read: the word is settled long before the capture edge
  assign o_data = mem[i_addr];
endmodule
`default_nettype wire

// >>> mcuie_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcuie_core_tb
  import mcuie_pkg::*;
;
  logic i_mclk;
  logic i_sys_rst;
  logic [PC_W-1:0] o_pmem_addr;
  logic [PWORD_W-1:0] i_pmem_data;
  logic [7:0] i_table_ptr;
  logic [1:0] i_table_page;
  logic o_wdt_clear;
  logic i_wdt_timeout;
  logic i_wake;
  logic [DATA_W-1:0] o_acc;
  logic o_carry_flag, o_nibble_carry_flag, o_zero_flag, o_signed_range_flag;
  logic o_watchdog_expired_flag, o_power_down_flag, o_global_irq_enable, o_sys_clk_stop;
  logic [DATA_W-1:0] o_table_high_byte;
  int n_fail = 0;
  int checked = 0;

  mcuie_core mcuie_core_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .o_pmem_addr(o_pmem_addr),
    .i_pmem_data(i_pmem_data), .i_table_ptr(i_table_ptr), .i_table_page(i_table_page),
    .i_wdt_timeout(i_wdt_timeout), .i_wake(i_wake), .i_irq_ack(1'b0), .o_acc(o_acc),
    .o_carry_flag(o_carry_flag), .o_nibble_carry_flag(o_nibble_carry_flag),
    .o_zero_flag(o_zero_flag), .o_signed_range_flag(o_signed_range_flag),
    .o_watchdog_expired_flag(o_watchdog_expired_flag),
    .o_power_down_flag(o_power_down_flag), .o_table_high_byte(o_table_high_byte),
    .o_global_irq_enable(o_global_irq_enable), .o_wdt_clear(o_wdt_clear),
    .o_sys_clk_stop(o_sys_clk_stop)
  );

  mcuie_pmem_model mcuie_pmem_model_i (.i_addr(o_pmem_addr), .o_data(i_pmem_data));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pm(input logic [9:0] a, input mcuie_op_e op, input logic [9:0] f);
    mcuie_pmem_model_i.mem[a] = {op, f};
  endtask

  // Waits for the next fetch address; clock count since the last arrival is its cost
  task automatic ex(input logic [9:0] a, input int c, input logic [7:0] acc);
    int n;
    n = 0;
    while (o_pmem_addr !== a && n < 64) begin
      @(negedge i_mclk);
      n++;
    end
    if (c > 0) chk("clocks", 16'(n), 16'(c));
    chk("fetch address", 16'(o_pmem_addr), 16'(a));
    chk("accumulator", 16'(o_acc), 16'(acc));
  endtask

  task automatic fl(input logic [3:0] e);
    chk("flags ov z nc c", {12'h000, o_signed_range_flag, o_zero_flag,
        o_nibble_carry_flag, o_carry_flag}, {12'h000, e});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_wdt_timeout = 1'b0;
    i_wake = 1'b0;
    i_table_ptr = 8'h05;
    i_table_page = 2'h2;
    for (int k = 0; k < 1024; k++) begin
      mcuie_pmem_model_i.mem[k] = 16'h0000;
    end
    pm(0, OP_MOVI, 10'h07F); pm(1, OP_MOVMA, 10'h010); pm(2, OP_MOVI, 10'h001);
    pm(3, OP_ADD, 10'h010); pm(4, OP_ADDI, 10'h080); pm(5, OP_ADCM, 10'h010);
    pm(6, OP_MOVAM, 10'h010); pm(7, OP_SUBI, 10'h081); pm(8, OP_XORI, 10'h0FF);
    pm(9, OP_CPLA, 10'h010); pm(10, OP_INCA, 10'h010); pm(11, OP_RLCA, 10'h010);
    pm(12, OP_RRA, 10'h010); pm(13, OP_SWAPA, 10'h010); pm(14, OP_BSET, 10'h010);
    pm(15, OP_MOVAM, 10'h010); pm(16, OP_BCLR, 10'h1D0); pm(17, OP_MOVAM, 10'h010);
    pm(18, OP_SDZ, 10'h010); pm(19, OP_MOVI, 10'h0FF); pm(20, OP_MOVAM, 10'h010);
    pm(21, OP_SNZB, 10'h010); pm(22, OP_CALL, 10'h040); pm(10'h040, OP_RETA, 10'h05A);
    pm(23, OP_MOVI, 10'h015); pm(24, OP_ADDI, 10'h027); pm(25, OP_BCD_FIXUP, 10'h011);
    pm(26, OP_MOVAM, 10'h011); pm(27, OP_PREWIPE1, 10'h000);
    pm(28, OP_PREWIPE1, 10'h000); pm(29, OP_PREWIPE2, 10'h000);
    pm(30, OP_JMP, 10'h050); pm(10'h050, OP_HALT, 10'h000);
    pm(10'h051, OP_WDT_CLEAR, 10'h000); pm(10'h052, OP_MOVI, 10'h060);
    pm(10'h053, OP_MOVMA, {4'h0, PC_LOW_ADDR}); pm(10'h061, OP_TBL_FINAL, 10'h012);
    pm(10'h062, OP_MOVAM, 10'h012); pm(10'h063, OP_CALL, 10'h070);
    pm(10'h070, OP_IRQ_RETURN, 10'h000);
    pm(10'h065, OP_TBL_PAGE, 10'h013); pm(10'h066, OP_MOVAM, 10'h013);
    pm(10'h067, OP_SETM, 10'h014); pm(10'h068, OP_MOVAM, 10'h014);
    pm(10'h069, OP_CLRM, 10'h014); pm(10'h06A, OP_MOVAM, 10'h014);
    mcuie_pmem_model_i.mem[10'h305] = 16'hA55A;
    mcuie_pmem_model_i.mem[10'h205] = 16'h3CC3;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    i_wdt_timeout <= 1'b1;
    @(posedge i_mclk);
    i_wdt_timeout <= 1'b0;
    ex(1, 0, 8'h7F);
    ex(2, 4, 8'h7F);
    ex(3, 4, 8'h01);
    ex(4, 4, 8'h80); fl(4'b1010);
    ex(5, 4, 8'h00); fl(4'b1101);
    ex(6, 4, 8'h00); fl(4'b1010);
    ex(7, 4, 8'h80); fl(4'b1010);
    ex(8, 4, 8'hFF); fl(4'b0000);
    ex(9, 4, 8'h00); fl(4'b0100);
    ex(10, 4, 8'h7F); fl(4'b0000);
    ex(11, 4, 8'h81);
    ex(12, 4, 8'h00); fl(4'b0001);
    ex(13, 4, 8'h40); fl(4'b0001);
    ex(14, 4, 8'h08);
    $display("test data ops done");
    ex(15, 4, 8'h08);
    ex(16, 4, 8'h81);
    ex(17, 4, 8'h81);
    ex(18, 4, 8'h01);
    ex(20, 4, 8'h01);
    ex(21, 8, 8'h00);
    ex(22, 4, 8'h00);
    ex(10'h040, 4, 8'h00);
    ex(23, 8, 8'h5A);
    ex(24, 8, 8'h15);
    ex(25, 4, 8'h3C);
    ex(26, 4, 8'h3C); fl(4'b0000);
    ex(27, 4, 8'h42);
    chk("expired flag", 16'(o_watchdog_expired_flag), 16'h0001);
    ex(28, 4, 8'h42);
    ex(29, 4, 8'h42);
    chk("wdt clear", 16'(o_wdt_clear), 16'h0000);
    chk("expired flag", 16'(o_watchdog_expired_flag), 16'h0001);
    ex(30, 4, 8'h42);
    chk("wdt clear", 16'(o_wdt_clear), 16'h0001);
    chk("expired flag", 16'(o_watchdog_expired_flag), 16'h0000);
    $display("test flow done");
    ex(10'h050, 4, 8'h42);
    ex(10'h051, 8, 8'h42);
    chk("wdt clear on halt", 16'(o_wdt_clear), 16'h0001);
    repeat (2) @(negedge i_mclk);
    chk("clock stop", 16'(o_sys_clk_stop), 16'h0001);
    chk("power down flag", 16'(o_power_down_flag), 16'h0001);
    @(posedge i_mclk);
    i_wdt_timeout <= 1'b1;
    @(posedge i_mclk);
    i_wdt_timeout <= 1'b0;
    repeat (8) @(negedge i_mclk);
    chk("halted address", 16'(o_pmem_addr), 16'h0051);
    chk("expired flag", 16'(o_watchdog_expired_flag), 16'h0001);
    @(posedge i_mclk);
    i_wake <= 1'b1;
    @(posedge i_mclk);
    i_wake <= 1'b0;
    ex(10'h052, 0, 8'h42);
    chk("wdt clear on clear", 16'(o_wdt_clear), 16'h0001);
    chk("clock stop", 16'(o_sys_clk_stop), 16'h0000);
    chk("wdt flags", 16'({o_watchdog_expired_flag, o_power_down_flag}), 16'h0000);
    ex(10'h053, 4, 8'h60);
    ex(10'h060, 4, 8'h60);
    ex(10'h061, 8, 8'h60);
    ex(10'h062, 8, 8'h60);
    chk("table high", 16'(o_table_high_byte), 16'h00A5);
    ex(10'h063, 4, 8'h5A);
    ex(10'h070, 4, 8'h5A);
    ex(10'h064, 8, 8'h5A);
    ex(10'h065, 8, 8'h5A);
    chk("irq enable", 16'(o_global_irq_enable), 16'h0001);
    ex(10'h066, 8, 8'h5A);
    chk("table high page", 16'(o_table_high_byte), 16'h003C);
    ex(10'h067, 4, 8'hC3);
    ex(10'h068, 4, 8'hC3);
    ex(10'h069, 4, 8'hFF);
    ex(10'h06A, 4, 8'hFF);
    ex(10'h06B, 4, 8'h00);
    $display("test power and table done");
    print_verdict();
  end

  // Whole program needs a few hundred clocks; this span leaves a wide margin
  initial begin
    repeat (3000) @(posedge i_mclk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
